/* File: tctr_cfg.svh */
// Register offsets, field positions and reset values of the timer.
// Assumes byte-wide registers on a small address space.
`ifndef TCTR_CFG_SVH
`define TCTR_CFG_SVH

`define TCTR_OFF_TSC    4'h0
`define TCTR_OFF_CNTH   4'h1
`define TCTR_OFF_CNTL   4'h2
`define TCTR_OFF_MODH   4'h3
`define TCTR_OFF_MODL   4'h4
`define TCTR_OFF_CH0SC  4'h5
`define TCTR_OFF_CH0H   4'h6
`define TCTR_OFF_CH0L   4'h7
`define TCTR_OFF_CH1SC  4'h8
`define TCTR_OFF_CH1H   4'h9
`define TCTR_OFF_CH1L   4'hA

`define TCTR_TSC_FLAG   7
`define TCTR_TSC_IE     6
`define TCTR_TSC_STOP   5
`define TCTR_TSC_RST    4
`define TCTR_PS_NONE    3'h7
`define TCTR_MOD_RST    8'hFF

`define TCTR_CH_FLAG    7
`define TCTR_CH_IE      6
`define TCTR_CH_MSB     5
`define TCTR_CH_MSA     4
`define TCTR_CH_ELB     3
`define TCTR_CH_ELA     2
`define TCTR_CH_TOV     1

`define TCTR_EL_PRESET  2'h0
`define TCTR_EL_TOGGLE  2'h1
`define TCTR_EL_CLEAR   2'h2
`define TCTR_EL_SET     2'h3

`endif

/* File: tctr_pkg.sv */
// Types and shared flag helpers of the timer.
// Assumes nothing beyond the config header for numbers.
package tctr_pkg;

  typedef enum logic [1:0] {
    TCTR_PRESET,
    TCTR_CAPTURE,
    TCTR_COMPARE,
    TCTR_BUFFERED
  } tctr_mode_e;

  // Set beats clear in the same cycle
  function automatic logic tctr_flag_next(input logic flag,
                                          input logic set,
                                          input logic clr);
    return set | (flag & ~clr);
  endfunction : tctr_flag_next

  // Read-then-write-0 clear; a new event disarms it
  function automatic logic tctr_arm_next(input logic arm,
                                         input logic flag,
                                         input logic rd,
                                         input logic set,
                                         input logic clr,
                                         input logic lock);
    if (set | clr)
      return 1'b0;
    if (rd & flag & ~lock)
      return 1'b1;
    return arm;
  endfunction : tctr_arm_next

endpackage : tctr_pkg

/* File: tctr_chan_if.sv */
// Link between the timer core and one channel.
// Assumes the core drives the timer side and the channel the rest.
`timescale 1ns/1ps
interface tctr_chan_if;
  logic [15:0] count;
  logic        upd;
  logic        ovf;
  logic        stopped;
  logic        brk_lock;
  logic [7:0]  wdata;
  logic        wr_sc;
  logic        rd_sc;
  logic        wr_h;
  logic        wr_l;
  logic        rd_h;
  logic        rd_l;
  logic        pin_s;
  logic        link_en;
  logic        link_off;
  logic [15:0] link_val;
  logic        link_wr;
  logic [7:0]  sc;
  logic [15:0] val;
  logic        pin_o;
  logic        pin_oe;
  logic        irq;
  logic        buf_on;

  modport timer (output count, upd, ovf, stopped, brk_lock, wdata,
                 wr_sc, rd_sc, wr_h, wr_l, rd_h, rd_l, pin_s,
                 link_en, link_off, link_val, link_wr,
                 input sc, val, pin_o, pin_oe, irq, buf_on);
  modport chan  (input count, upd, ovf, stopped, brk_lock, wdata,
                 wr_sc, rd_sc, wr_h, wr_l, rd_h, rd_l, pin_s,
                 link_en, link_off, link_val, link_wr,
                 output sc, val, pin_o, pin_oe, irq, buf_on);
endinterface : tctr_chan_if

/* File: tctr_channel.sv */
// One capture/compare channel with its control and value registers.
// Assumes strobes and the synchronised pin come from the timer core.
`timescale 1ns/1ps
`include "tctr_cfg.svh"
module tctr_channel import tctr_pkg::*; (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic reset_n_i,
  // Core link
  tctr_chan_if.chan c
);

  logic        flag, arm, ie, msb, msa, tov;
  logic [1:0]  el;
  logic [15:0] val;
  logic        cmp_hold, cap_hold, pin_q;
  logic        out_lvl, oe, irq, use_link, next_link, next_out;
  tctr_mode_e  mode;

  wire dis    = c.link_off;
  wire is_out = (mode == TCTR_COMPARE) || (mode == TCTR_BUFFERED);
  wire edge_hit = (el[0] & c.pin_s & ~pin_q) | (el[1] & ~c.pin_s & pin_q);
  wire [15:0] cmp_val = use_link ? c.link_val : val;
  wire cap_ev = (mode == TCTR_CAPTURE) && !c.stopped && !cap_hold
                && edge_hit;
  wire cmp_ev = is_out && c.upd && !cmp_hold
                && (c.count == cmp_val);
  wire ev     = cap_ev | cmp_ev;
  wire clr    = c.wr_sc && !dis && !c.wdata[`TCTR_CH_FLAG] && arm
                && !c.brk_lock;
  wire next_flag = tctr_flag_next(flag, ev, clr);

  // Channel 1 reverts to port control under buffered mode
  assign mode = dis ? TCTR_PRESET :
                (el == `TCTR_EL_PRESET) ? TCTR_PRESET :
                (msb && c.link_en) ? TCTR_BUFFERED :
                msa ? TCTR_COMPARE : TCTR_CAPTURE;

  always_comb begin
    next_out = out_lvl;
    case (mode)
      TCTR_PRESET:   next_out = ~msa;
      TCTR_CAPTURE:  next_out = out_lvl;
      TCTR_COMPARE,
      TCTR_BUFFERED: begin
        if (c.ovf && tov)
          next_out = ~out_lvl;
        else if (cmp_ev) begin
          case (el)
            `TCTR_EL_TOGGLE: next_out = ~out_lvl;
            `TCTR_EL_CLEAR:  next_out = 1'b0;
            `TCTR_EL_SET:    next_out = 1'b1;
            default:         next_out = out_lvl;
          endcase
        end
      end
      default: next_out = out_lvl;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag <= 1'b0;
      arm  <= 1'b0;
      irq  <= 1'b0;
      {ie, msb, msa, el, tov} <= 6'h00;
    end else begin
      flag <= next_flag;
      arm  <= tctr_arm_next(arm, flag, c.rd_sc, ev, clr, c.brk_lock);
      irq  <= next_flag & ie;
      if (c.wr_sc && !dis) begin
        ie  <= c.wdata[`TCTR_CH_IE];
        msb <= c.wdata[`TCTR_CH_MSB] & c.link_en;
        msa <= c.wdata[`TCTR_CH_MSA];
        el  <= c.wdata[`TCTR_CH_ELB:`TCTR_CH_ELA];
        tov <= c.wdata[`TCTR_CH_TOV];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      val      <= 16'h0000;
      cmp_hold <= 1'b0;
      cap_hold <= 1'b0;
    end else begin
      if (cap_ev)
        val <= c.count;
      else begin
        if (c.wr_h) val[15:8] <= c.wdata;
        if (c.wr_l) val[7:0]  <= c.wdata;
      end
      if (c.wr_l) cmp_hold <= 1'b0;
      else if (c.wr_h && mode != TCTR_CAPTURE) cmp_hold <= 1'b1;
      if (c.rd_l) cap_hold <= 1'b0;
      else if (c.rd_h && mode == TCTR_CAPTURE) cap_hold <= 1'b1;
    end
  end

  // Buffered pair: last-written registers take over at overflow
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_q     <= 1'b0;
      out_lvl   <= 1'b1;
      oe        <= 1'b0;
      use_link  <= 1'b0;
      next_link <= 1'b0;
    end else begin
      pin_q   <= c.pin_s;
      out_lvl <= next_out;
      oe      <= is_out;
      if (c.link_wr) next_link <= 1'b1;
      else if (c.wr_l) next_link <= 1'b0;
      if (mode != TCTR_BUFFERED) use_link <= 1'b0;
      else if (c.ovf) use_link <= next_link;
    end
  end

  assign c.sc     = {flag, ie, msb, msa, el, tov, 1'b0};
  assign c.val    = val;
  assign c.pin_o  = out_lvl;
  assign c.pin_oe = oe;
  assign c.irq    = irq;
  assign c.buf_on = msb;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  cap_when_stop_a: assert property (
    (c.stopped && !c.wr_h && !c.wr_l) |=> $stable(val))
    else $error("capture taken while stopped");
  chan_flag_keep_a: assert property (
    (c.wr_sc && !arm && flag) |=> flag)
    else $error("channel flag cleared without read");

endmodule : tctr_channel

/* File: tctr_top.sv */
// Sixteen-bit timer core with two capture/compare channels.
// Assumes a byte register port on the same clock; channel pins are async.
//
// Function
// - Break state halts the counter
// - Clear enable lets break clears stick
// - Without clear enable, break leaves flags alone
// - Overflow flag clears by read then write 0
// - Overflow enable gates the overflow request
// - Stop bit freezes counter, set at reset
// - Stop bit blocks input captures
// - Counter reset clears counter and prescaler
// - Stop plus reset leaves counter at zero
// - Prescaler divides by one to sixty-four
// - High-byte read latches low counter byte
// - Modulo match sets flag, counter wraps
// - Modulo high write blocks overflow until low
// - Modulo registers reset to all ones
// - Channel flag on edge or compare match
// - Channel flag clears by read then write 0
// - Channel enable gates channel request
// - Buffered bit links channel 1 into 0
// - Mode bit A picks compare or level
// - Each channel capture or compare independently
// - Edge/level field selects edge or action
// - Overflow toggle beats coincident compare
// - Value byte order blocks compare or capture
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "tctr_cfg.svh"
module tctr_top import tctr_pkg::*; #(
  parameter int NCH = 2
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  // Register port
  input  wire logic [3:0]       addr_i,
  input  wire logic [7:0]       wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [7:0]       rdata_o,
  // System state
  input  wire logic             break_i,
  input  wire logic             break_clear_enable_i,
  input  wire logic             wait_mode_i,
  // Channel pins
  input  wire logic [NCH-1:0]   chan_pin_i,
  output wire       [NCH-1:0]   chan_pin_o,
  output wire       [NCH-1:0]   chan_pin_oe_o,
  // Interrupt requests
  output logic                  overflow_irq_o,
  output wire       [NCH-1:0]   chan_irq_o
);

  logic        overflow_flag, tof_arm, overflow_irq_enable, stop;
  logic [2:0]  ps;
  logic [5:0]  presc;
  logic [15:0] count;
  logic        upd;
  logic [7:0]  modh, modl;
  logic        mod_hold;
  logic        cnt_latched;
  logic [7:0]  lbuf;
  logic [NCH-1:0] pin_m, pin_s;

  function automatic logic [5:0] ps_mask(input logic [2:0] sel);
    logic [5:0] m;
    m = 6'h00;
    for (int i = 0; i < 6; i++)
      m[i] = (i < int'(sel));
    return m;
  endfunction : ps_mask

  // Wait mode: registers unreachable, timer keeps running
  wire wr_ok = wr_i && !wait_mode_i;
  wire rd_ok = rd_i && !wait_mode_i;

  wire wr_tsc   = wr_ok && (addr_i == `TCTR_OFF_TSC);
  wire rd_tsc   = rd_ok && (addr_i == `TCTR_OFF_TSC);
  wire rd_cnthi = rd_ok && (addr_i == `TCTR_OFF_CNTH);
  wire rd_cntlo = rd_ok && (addr_i == `TCTR_OFF_CNTL);
  wire wr_modh  = wr_ok && (addr_i == `TCTR_OFF_MODH);
  wire wr_modl  = wr_ok && (addr_i == `TCTR_OFF_MODL);

  // Flags cannot be cleared during break unless clearing is enabled
  wire lock     = break_i && !break_clear_enable_i;
  wire halted   = stop || break_i;
  wire rst_cnt  = wr_tsc && wdata_i[`TCTR_TSC_RST];
  wire [5:0] pmask = ps_mask(ps);
  wire tick     = !halted && (ps != `TCTR_PS_NONE)
                  && ((presc & pmask) == pmask);
  wire [15:0] modv = {modh, modl};
  wire at_mod   = (count == modv);
  wire ovf      = upd && at_mod && !mod_hold;
  wire tof_clr  = wr_tsc && !wdata_i[`TCTR_TSC_FLAG] && tof_arm
                  && !lock;
  wire next_tof = tctr_flag_next(overflow_flag, ovf, tof_clr);

  wire [7:0] tsc_rd = {overflow_flag, overflow_irq_enable, stop, 1'b0, 1'b0, ps};
  wire [7:0] cnt_lo = cnt_latched ? lbuf : count[7:0];

  // Status, control and overflow flag
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      overflow_flag     <= 1'b0;
      tof_arm <= 1'b0;
      overflow_irq_enable    <= 1'b0;
      stop    <= 1'b1;
      ps      <= 3'h0;
    end else begin
      overflow_flag     <= next_tof;
      tof_arm <= tctr_arm_next(tof_arm, overflow_flag, rd_tsc, ovf, tof_clr,
                               lock);
      if (wr_tsc) begin
        overflow_irq_enable <= wdata_i[`TCTR_TSC_IE];
        stop <= wdata_i[`TCTR_TSC_STOP];
        ps   <= wdata_i[2:0];
      end
    end
  end

  // Prescaler and counter
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      presc <= 6'h00;
      count <= 16'h0000;
      upd   <= 1'b0;
    end else begin
      upd <= tick && !rst_cnt;
      if (rst_cnt)
        presc <= 6'h00;
      else if (!halted)
        presc <= presc + 6'h01;
      if (rst_cnt)
        count <= 16'h0000;
      else if (tick)
        count <= at_mod ? 16'h0000 : count + 16'h0001;
    end
  end

  // Modulo and latched low byte
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      modh        <= `TCTR_MOD_RST;
      modl        <= `TCTR_MOD_RST;
      mod_hold    <= 1'b0;
      cnt_latched <= 1'b0;
      lbuf        <= 8'h00;
    end else begin
      if (wr_modh) modh <= wdata_i;
      if (wr_modl) modl <= wdata_i;
      if (wr_modl) mod_hold <= 1'b0;
      else if (wr_modh) mod_hold <= 1'b1;
      if (rst_cnt || rd_cntlo) begin
        cnt_latched <= 1'b0;
        lbuf        <= 8'h00;
      end else if (rd_cnthi && !cnt_latched) begin
        cnt_latched <= 1'b1;
        lbuf        <= count[7:0];
      end
    end
  end

  // Two-flop pin synchronisers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_m <= '0;
      pin_s <= '0;
    end else begin
      pin_m <= chan_pin_i;
      pin_s <= pin_m;
    end
  end

  tctr_chan_if chif[NCH] ();
  logic [7:0] ch_rd [NCH];
  logic [NCH-1:0] ch_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      localparam logic [3:0] SC_OFF = gi ? `TCTR_OFF_CH1SC
                                         : `TCTR_OFF_CH0SC;
      localparam logic [3:0] H_OFF  = gi ? `TCTR_OFF_CH1H
                                         : `TCTR_OFF_CH0H;
      localparam logic [3:0] L_OFF  = gi ? `TCTR_OFF_CH1L
                                         : `TCTR_OFF_CH0L;
      wire s_sc = (addr_i == SC_OFF);
      wire s_h  = (addr_i == H_OFF);
      wire s_l  = (addr_i == L_OFF);

      assign chif[gi].count    = count;
      assign chif[gi].upd      = upd;
      assign chif[gi].ovf      = ovf;
      assign chif[gi].stopped  = stop;
      assign chif[gi].brk_lock = lock;
      assign chif[gi].wdata    = wdata_i;
      assign chif[gi].wr_sc    = wr_ok && s_sc;
      assign chif[gi].rd_sc    = rd_ok && s_sc;
      assign chif[gi].wr_h     = wr_ok && s_h;
      assign chif[gi].wr_l     = wr_ok && s_l;
      assign chif[gi].rd_h     = rd_ok && s_h;
      assign chif[gi].rd_l     = rd_ok && s_l;
      assign chif[gi].pin_s    = pin_s[gi];
      // Only channel 0 can host the buffered pair
      assign chif[gi].link_en  = (gi == 0);
      assign chif[gi].link_off = gi ? chif[0].buf_on : 1'b0;
      assign chif[gi].link_val = chif[NCH-1-gi].val;
      assign chif[gi].link_wr  = chif[NCH-1-gi].wr_l;

      assign ch_hit[gi] = s_sc | s_h | s_l;
      assign ch_rd[gi]  = s_sc ? chif[gi].sc :
                          s_h  ? chif[gi].val[15:8] :
                          s_l  ? chif[gi].val[7:0] : 8'h00;

      assign chan_pin_o[gi]    = chif[gi].pin_o;
      assign chan_pin_oe_o[gi] = chif[gi].pin_oe;
      assign chan_irq_o[gi]    = chif[gi].irq;

      tctr_channel u_chan (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .c         (chif[gi])
      );
    end
  endgenerate

  logic [7:0] ch_mux;
  always_comb begin
    ch_mux = 8'h00;
    for (int i = 0; i < NCH; i++)
      if (ch_hit[i]) ch_mux = ch_rd[i];
  end

  // Unmapped offsets read as zero
  wire [7:0] rd_mux =
    (addr_i == `TCTR_OFF_TSC)  ? tsc_rd :
    (addr_i == `TCTR_OFF_CNTH) ? count[15:8] :
    (addr_i == `TCTR_OFF_CNTL) ? cnt_lo :
    (addr_i == `TCTR_OFF_MODH) ? modh :
    (addr_i == `TCTR_OFF_MODL) ? modl : ch_mux;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o        <= 8'h00;
      overflow_irq_o <= 1'b0;
    end else begin
      rdata_o        <= rd_ok ? rd_mux : 8'h00;
      overflow_irq_o <= next_tof & overflow_irq_enable;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  halt_in_break_a: assert property (
    (break_i && !rst_cnt) |=> $stable(count))
    else $error("counter moved during break");
  brk_flag_lock_a: assert property (
    (lock && overflow_flag) |=> overflow_flag)
    else $error("overflow flag cleared in protected break");
  tof_clear_seq_a: assert property (
    (wr_tsc && !tof_arm && overflow_flag) |=> overflow_flag)
    else $error("overflow flag cleared without read");
  ovf_irq_req_a: assert property (
    ($rose(overflow_flag) && $past(overflow_irq_enable)) |-> overflow_irq_o)
    else $error("overflow request missing");
  stop_freeze_a: assert property (
    (stop && !rst_cnt) |=> $stable(count))
    else $error("counter moved while stopped");
  cnt_reset_a: assert property (
    rst_cnt |=> (count == 16'h0000) && (presc == 6'h00))
    else $error("counter reset incomplete");
  stop_rst_zero_a: assert property (
    (wr_tsc && wdata_i[`TCTR_TSC_STOP] && wdata_i[`TCTR_TSC_RST])
    ##1 !wr_tsc[*3] |-> (count == 16'h0000))
    else $error("stopped counter not at zero");
  div_two_a: assert property (
    (ps == 3'h1 && tick && !wr_tsc) |=> !tick)
    else $error("divide by two ticked twice");
  latch_hold_a: assert property (
    (cnt_latched && !rd_cntlo && !rst_cnt) |=> $stable(lbuf))
    else $error("latched low byte changed");
  mod_wrap_a: assert property (
    (tick && at_mod && !rst_cnt) |=> (count == 16'h0000) && upd)
    else $error("counter did not wrap at modulo");
  mod_hold_a: assert property (mod_hold |-> !ovf)
    else $error("overflow while modulo write open");

  // Overflow flag and its request
  tof_set_a: assert property (
    ovf |=> overflow_flag)
    else $error("overflow flag not set at modulo");
  tof_one_write_a: assert property (
    (wr_tsc && wdata_i[`TCTR_TSC_FLAG] && overflow_flag) |=> overflow_flag)
    else $error("writing one cleared overflow flag");
  brk_clear_a: assert property (
    (break_i && tof_clr && !ovf) |=> !overflow_flag)
    else $error("enabled break clear did not stick");
  brk_no_arm_a: assert property (
    (lock && !tof_arm && !ovf) |=> !tof_arm)
    else $error("clear armed during protected break");
  ovf_irq_gate_a: assert property (
    !overflow_irq_enable |=> !overflow_irq_o)
    else $error("overflow request while disabled");
  ovf_irq_hold_a: assert property (
    (overflow_flag && overflow_irq_enable && !tof_clr) |=> overflow_irq_o)
    else $error("overflow request dropped");

  // Counter and prescaler
  cnt_step_a: assert property (
    (tick && !at_mod && !rst_cnt) |=> (count == $past(count) + 16'h0001))
    else $error("counter did not step by one");
  presc_halt_a: assert property (
    (halted && !rst_cnt) |=> $stable(presc))
    else $error("prescaler ran while halted");
  ps_none_a: assert property (
    (ps == `TCTR_PS_NONE && !rst_cnt) |=> $stable(count))
    else $error("counter moved with no clock source");
  div_one_a: assert property (
    (ps == 3'h0 && !halted) |-> tick)
    else $error("divide by one missed a tick");
  mod_hold_set_a: assert property (
    wr_modh |=> mod_hold)
    else $error("modulo high write did not block");

  // Counter latch and register port
  latch_take_a: assert property (
    (rd_cnthi && !cnt_latched && !rst_cnt) |=>
    (cnt_latched && (lbuf == $past(cnt_lo))))
    else $error("low byte not latched");
  latch_read_a: assert property (
    (rd_cntlo && cnt_latched) |=> (rdata_o == $past(lbuf)))
    else $error("latched low byte not returned");
  wait_rd_zero_a: assert property (
    wait_mode_i |=> (rdata_o == 8'h00))
    else $error("register read in wait mode");
  wait_keep_a: assert property (
    wait_mode_i |=> ($stable(modh) && $stable(modl) && $stable(overflow_irq_enable)))
    else $error("register written in wait mode");
  wait_runs_a: assert property (
    (wait_mode_i && tick && !at_mod) |=> (count != $past(count)))
    else $error("counter halted in wait mode");

endmodule : tctr_top

/* File: tctr_pin_model.sv */
// Far side of the two shared channel pins.
// Assumes the bench asks for levels; a pin the timer drives wins.
`timescale 1ns/1ps
module tctr_pin_model (
  // Clock
  input  wire logic       mclk_i,
  // Wanted external level
  input  wire logic [1:0] level_i,
  // Timer pin side
  input  wire logic [1:0] pin_o_i,
  input  wire logic [1:0] pin_oe_i,
  output logic      [1:0] pin_o
);
  logic [1:0] ext = 2'h0;

  // Source changes just after an edge, never mid-cycle
  always @(posedge mclk_i) begin
    ext <= level_i;
  end

  assign pin_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext);
endmodule : tctr_pin_model

/* File: tb_top.sv */
// Self-checking bench of the timer over its byte register port.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "tctr_cfg.svh"
module tb_top;
  typedef struct packed {logic [7:0] v; logic cmp;} tctr_note_s;
  logic        mclk_i    = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  addr_i    = 4'h0;
  logic [7:0]  wdata_i   = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        break_i   = 1'b0;
  logic        bce       = 1'b0;
  logic        wait_i    = 1'b0;
  logic [1:0]  level     = 2'h0;
  logic        pend      = 1'b0;
  logic [7:0]  rdata_o;
  logic [1:0]  pin_in;
  logic [1:0]  pin_o;
  logic [1:0]  pin_oe;
  logic [1:0]  chan_irq;
  logic        ovf_irq;
  logic [7:0]  rv;
  logic [15:0] v1;
  logic [15:0] v2;
  int          n_errors  = 0;
  int          checks    = 0;
  tctr_note_s  notes[$];
  tctr_note_s  nt;
  logic [7:0]  seen[$];

  tctr_top i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .break_i(break_i), .break_clear_enable_i(bce), .wait_mode_i(wait_i),
    .chan_pin_i(pin_in), .chan_pin_o(pin_o), .chan_pin_oe_o(pin_oe),
    .overflow_irq_o(ovf_irq), .chan_irq_o(chan_irq));
  tctr_pin_model i_pins (.mclk_i(mclk_i), .level_i(level),
    .pin_o_i(pin_o), .pin_oe_i(pin_oe), .pin_o(pin_in));

  always #2.5 mclk_i = ~mclk_i;

  task automatic summarize();
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt

  // One strobe cycle, then a free cycle so no strobe is set twice
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input logic c);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= w;
    rd_i    <= ~w;
    if (!w)
      notes.push_back('{d, c});
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : acc

  // Two latched counter reads exactly gap cycles apart
  task automatic meas(input int gap, input logic [15:0] exp);
    seen.delete();
    for (int k = 0; k < 2; k++) begin
      acc(0, `TCTR_OFF_CNTH, 8'h00, 0);
      acc(0, `TCTR_OFF_CNTL, 8'h00, 0);
      if (k == 0)
        wt(gap - 4);
    end
    wt(2);
    v1 = {seen[0], seen[1]};
    v2 = {seen[2], seen[3]};
    chk(v2 - v1, exp);
  endtask : meas

  task automatic step(input logic [7:0] cfg, input logic lv, input logic f);
    acc(0, `TCTR_OFF_CH0SC, 8'h00, 0);
    acc(1, `TCTR_OFF_CH0SC, cfg, 0);
    level[0] <= lv;
    wt(8);
    acc(0, `TCTR_OFF_CH0SC, {f, cfg[6:0]}, 1);
    wt(1);
    chk(chan_irq[0], f);
  endtask : step

  always @(posedge mclk_i) begin
    if (pend) begin
      nt = notes.pop_front();
      if (nt.cmp)
        chk(rdata_o, nt.v);
      else
        seen.push_back(rdata_o);
    end
    pend <= rd_i;
  end

  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(58));
    wt(6);
    reset_n_i <= 1'b1;
    acc(0, `TCTR_OFF_TSC, 8'h20, 1);
    acc(0, `TCTR_OFF_MODH, 8'hFF, 1);
    acc(0, `TCTR_OFF_MODL, 8'hFF, 1);
    acc(0, `TCTR_OFF_CNTH, 8'h00, 1);
    acc(0, `TCTR_OFF_CH1SC, 8'h00, 1);
    acc(0, 4'hB, 8'h00, 1);
    for (int i = 0; i < 8; i++) begin
      acc(1, `TCTR_OFF_TSC, 8'h30, 0);
      acc(1, `TCTR_OFF_TSC, 8'(i), 0);
      meas(i < 7 ? 16 << i : 64, i < 7 ? 16'h0010 : 16'h0000);
    end
    acc(1, `TCTR_OFF_TSC, 8'h00, 0);
    break_i <= 1'b1;
    meas(40, 16'h0000);
    break_i <= 1'b0;
    acc(1, `TCTR_OFF_TSC, 8'h30, 0);
    acc(0, `TCTR_OFF_CNTH, 8'h00, 1);
    acc(0, `TCTR_OFF_CNTL, 8'h00, 1);
    acc(0, `TCTR_OFF_TSC, 8'h20, 1);
    acc(1, `TCTR_OFF_MODH, 8'h00, 0);
    acc(1, `TCTR_OFF_TSC, 8'h40, 0);
    wt(300);
    chk(ovf_irq, 1'b0);
    acc(0, `TCTR_OFF_TSC, 8'h40, 1);
    acc(1, `TCTR_OFF_TSC, 8'h70, 0);
    acc(1, `TCTR_OFF_MODL, 8'h05, 0);
    acc(1, `TCTR_OFF_TSC, 8'h40, 0);
    wt(20);
    chk(ovf_irq, 1'b1);
    acc(1, `TCTR_OFF_TSC, 8'h60, 0);
    acc(0, `TCTR_OFF_TSC, 8'hE0, 1);
    acc(1, `TCTR_OFF_TSC, 8'hE0, 0);
    acc(0, `TCTR_OFF_TSC, 8'hE0, 1);
    break_i <= 1'b1;
    acc(1, `TCTR_OFF_TSC, 8'h60, 0);
    acc(0, `TCTR_OFF_TSC, 8'hE0, 1);
    break_i <= 1'b0;
    acc(1, `TCTR_OFF_TSC, 8'h60, 0);
    acc(0, `TCTR_OFF_TSC, 8'h60, 1);
    chk(ovf_irq, 1'b0);
    acc(1, `TCTR_OFF_TSC, 8'h40, 0);
    wt(10);
    acc(1, `TCTR_OFF_TSC, 8'h60, 0);
    break_i <= 1'b1;
    bce     <= 1'b1;
    acc(0, `TCTR_OFF_TSC, 8'hE0, 1);
    acc(1, `TCTR_OFF_TSC, 8'h60, 0);
    break_i <= 1'b0;
    bce     <= 1'b0;
    acc(0, `TCTR_OFF_TSC, 8'h60, 1);
    step(8'h44, 1'b1, 1'b0);
    step(8'h44, 1'b0, 1'b0);
    acc(1, `TCTR_OFF_TSC, 8'h00, 0);
    for (int e = 1; e < 4; e++) begin
      step(8'h40 | 8'(e << 2), 1'b1, e[0]);
      step(8'h40 | 8'(e << 2), 1'b0, e[1]);
    end
    acc(1, `TCTR_OFF_TSC, 8'h30, 0);
    acc(1, `TCTR_OFF_CH1SC, 8'h10, 0);
    wt(2);
    chk(pin_oe[1], 1'b0);
    chk(pin_o[1], 1'b0);
    acc(1, `TCTR_OFF_CH1SC, 8'h00, 0);
    wt(2);
    chk(pin_o[1], 1'b1);
    rv = 8'($urandom_range(4, 1));
    acc(1, `TCTR_OFF_CH1H, 8'h00, 0);
    acc(1, `TCTR_OFF_CH1L, rv, 0);
    for (int j = 0; j < 2; j++) begin
      acc(1, `TCTR_OFF_TSC, 8'h30, 0);
      acc(1, `TCTR_OFF_CH1SC, 8'h18 | 8'(j << 2), 0);
      acc(1, `TCTR_OFF_TSC, 8'h00, 0);
      wt(20);
      acc(1, `TCTR_OFF_TSC, 8'h20, 0);
      acc(0, `TCTR_OFF_CH1SC, 8'h98 | 8'(j << 2), 1);
      acc(1, `TCTR_OFF_CH1SC, 8'h18 | 8'(j << 2), 0);
      chk(pin_oe[1], 1'b1);
      chk(pin_o[1], j[0]);
    end
    acc(1, `TCTR_OFF_TSC, 8'h30, 0);
    acc(1, `TCTR_OFF_CH1SC, 8'h5E, 0);
    acc(1, `TCTR_OFF_CH1L, 8'h05, 0);
    acc(1, `TCTR_OFF_TSC, 8'h00, 0);
    wt(8);
    acc(1, `TCTR_OFF_TSC, 8'h20, 0);
    chk(pin_o[1], 1'b0);
    chk(chan_irq[1], 1'b1);
    acc(0, `TCTR_OFF_CH1SC, 8'hDE, 1);
    acc(1, `TCTR_OFF_CH1SC, 8'h5E, 0);
    acc(1, `TCTR_OFF_CH1H, 8'h00, 0);
    acc(1, `TCTR_OFF_TSC, 8'h00, 0);
    wt(20);
    acc(1, `TCTR_OFF_TSC, 8'h20, 0);
    acc(0, `TCTR_OFF_CH1SC, 8'h5E, 1);
    chk(chan_irq[1], 1'b0);
    acc(1, `TCTR_OFF_CH1L, 8'h05, 0);
    acc(1, `TCTR_OFF_CH0SC, 8'h28, 0);
    wt(3);
    chk(pin_oe[1], 1'b0);
    chk(pin_oe[0], 1'b1);
    acc(1, `TCTR_OFF_CH1SC, 8'h00, 0);
    acc(0, `TCTR_OFF_CH1SC, 8'h5E, 1);
    acc(1, `TCTR_OFF_TSC, 8'h00, 0);
    wt(20);
    chk(pin_o[0], 1'b0);
    wait_i <= 1'b1;
    acc(1, `TCTR_OFF_MODH, 8'hAA, 0);
    acc(0, `TCTR_OFF_MODH, 8'h00, 1);
    wait_i <= 1'b0;
    acc(0, `TCTR_OFF_MODH, 8'h00, 1);
    wt(4);
    summarize();
  end
endmodule : tb_top
